// >>> secure_ctrl_pkg.sv
// Constants, types and register map of the secure mode and fuse area controller.
package secure_ctrl_pkg;

  localparam int DATA_W = 8;
  localparam int NUM_RAMS = 2;

  // Mode encodings, Gray coded along startup, vendor, system.
  typedef enum logic [1:0] {
    MODE_STARTUP = 2'b00,
    MODE_VENDOR = 2'b01,
    MODE_SYSTEM = 2'b11,
    MODE_FACTORY = 2'b10
  } mode_type;

  // One word returned by a memory, with its stored parity bit.
  typedef struct packed {
    logic valid;
    logic [DATA_W-1:0] data;
    logic par;
  } mem_word_type;

  // Configuration fuses as loaded from storage, with their parity bit.
  typedef struct packed {
    logic card_dis_allowed;
    logic erase_allowed;
    logic ram2_rd_par_en;
    logic ram1_rd_par_en;
    logic par;
  } fuse_word_type;

  // Register byte offsets.
  localparam logic [11:0] OFS_MODE = 12'h000;
  localparam logic [11:0] OFS_LIFE = 12'h004;
  localparam logic [11:0] OFS_CONFIG = 12'h008;
  localparam logic [11:0] OFS_MAP = 12'h00c;
  localparam logic [11:0] OFS_PROT = 12'h010;
  localparam logic [11:0] OFS_CAUSE = 12'h014;
  localparam logic [11:0] OFS_RO_AREA = 12'h100;
  localparam logic [11:0] OFS_WP_AREA = 12'h120;
  localparam logic [11:0] OFS_WO_AREA = 12'h130;

  // Area sizes in bytes and in words; the whole manufacturer area.
  localparam int MFR_AREA_BYTES = 768;
  localparam int RO_BYTES = 32;
  localparam int WP_BYTES = 16;
  localparam int WO_BYTES = 32;
  localparam int RO_WORDS = RO_BYTES / 4;
  localparam int WP_WORDS = WP_BYTES / 4;
  localparam int WO_WORDS = WO_BYTES / 4;

  // Designated write-once bytes.
  localparam int CARD_DIS_BYTE = 0;
  localparam int ERASE_BYTE = 1;

  // Field positions.
  localparam int LIFE_DELIVERED_BIT = 0;
  localparam int LIFE_BOOT_OFF_BIT = 1;
  localparam int CONFIG_LOADED_BIT = 4;
  localparam int CONFIG_BLOCKED_BIT = 5;
  localparam int MAP_SYS_BIT = 0;
  localparam int PROT_WP_BIT = 0;
  localparam int CAUSE_ROM_BIT = 0;
  localparam int CAUSE_NVM_BIT = 1;
  localparam int CAUSE_SCAN_BIT = 2;
  localparam int CAUSE_RD_BIT = 3;
  localparam int CAUSE_FUSE_BIT = 4;
  localparam int CAUSE_W = 5;

  // Reset values.
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;

  // Hamming code word: bit 0 overall parity, bits 1 to 12 Hamming positions.
  localparam int ECC_W = 13;

endpackage

// >>> secure_ctrl.sv
// Secure mode sequencer, manufacturer area guard and memory integrity reset logic.
`timescale 1ns/1ps

// What this block does
// - ROM read parity failure forces chip reset.
// - Correct single-bit errors in nonvolatile words.
// - Uncorrectable nonvolatile error forces chip reset.
// - Background parity scan per RAM resets chip.
// - Optional per-RAM read parity check resets.
// - Reset always places CPU in startup.
// - Startup reachable only through reset.
// - Startup leads only to factory or vendor.
// - Vendor state never enters factory state.
// - Delivery blocks factory entry, disables test ROM.
// - Bootloader disabled permanently before delivery.
// - Manufacturer area at reserved top addresses; here at offsets 0x100 to 0x14f, well above the registers at 0x000 to 0x017.
// - Area access depends on mode and mapping.
// - Fuses parity-checked at load and stored.
// - Read-only region never writable by software.
// - Protectable region refuses writes once protected.
// - Write-once bits only set, never cleared.
// - Card-disable byte refuses startup after reset.
// - Erase byte destroys application nonvolatile contents.
module secure_ctrl #(
  parameter int RAM_AW = 10,
  parameter logic [8*secure_ctrl_pkg::RO_BYTES-1:0] RO_CONTENT = '0
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic por_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire secure_ctrl_pkg::fuse_word_type fuse_in,
  input wire secure_ctrl_pkg::mem_word_type rom_word,
  input wire logic nvm_rd_valid,
  input wire logic [secure_ctrl_pkg::ECC_W-1:0] nvm_rd_code,
  output logic nvm_out_valid,
  output logic [secure_ctrl_pkg::DATA_W-1:0] nvm_out_data,
  output logic nvm_out_corrected,
  output logic [RAM_AW-1:0] ram_scan_addr [secure_ctrl_pkg::NUM_RAMS],
  input wire secure_ctrl_pkg::mem_word_type ram_scan_word [secure_ctrl_pkg::NUM_RAMS],
  input wire secure_ctrl_pkg::mem_word_type ram_sw_word [secure_ctrl_pkg::NUM_RAMS],
  output logic chip_reset_req,
  output secure_ctrl_pkg::mode_type cpu_mode,
  output logic test_rom_en,
  output logic bootloader_en,
  output logic card_disabled,
  output logic erase_all
);

  secure_ctrl_pkg::mode_type mode_r;
  secure_ctrl_pkg::fuse_word_type fuse_r;
  logic fuse_loaded_r;
  logic startup_blocked_r;
  logic delivered_r;
  logic boot_off_r;
  logic map_sys_r;
  logic wp_locked_r;
  logic [secure_ctrl_pkg::CAUSE_W-1:0] cause_r;
  logic [secure_ctrl_pkg::CAUSE_W-1:0] err_now;
  logic chip_reset_req_r;
  logic [7:0] wp_mem [secure_ctrl_pkg::WP_BYTES];
  logic [7:0] wo_mem [secure_ctrl_pkg::WO_BYTES];
  logic [RAM_AW-1:0] scan_addr_r [secure_ctrl_pkg::NUM_RAMS];
  logic [31:0] prdata_r;
  logic pslverr_r;
  logic nvm_out_valid_r;
  logic [secure_ctrl_pkg::DATA_W-1:0] nvm_out_data_r;
  logic nvm_out_corrected_r;
  logic nvm_double_err;
  logic fuse_err;
  logic setup_ph;
  logic wr_acc;
  logic area_ok;
  logic [3:0] wp_idx;
  logic [3:0] wo_idx;
  logic [3:0] ro_idx;
  logic in_ro;
  logic in_wp;
  logic in_wo;
  logic [31:0] rd_word;
  logic rd_err;

  function automatic logic even_par(input logic [secure_ctrl_pkg::DATA_W-1:0] d);
    even_par = ^d;
  endfunction

  // True when a returned memory word carries a parity mismatch.
  function automatic logic par_fail(input secure_ctrl_pkg::mem_word_type w);
    par_fail = w.valid && (w.par != even_par(w.data));
  endfunction

  function automatic logic fuse_par(input secure_ctrl_pkg::fuse_word_type f);
    fuse_par = f.card_dis_allowed ^ f.erase_allowed ^ f.ram2_rd_par_en ^ f.ram1_rd_par_en;
  endfunction

  // Legal mode transitions; nothing ever returns to startup.
  function automatic logic mode_step_ok(
    input secure_ctrl_pkg::mode_type cur,
    input secure_ctrl_pkg::mode_type req,
    input logic delivered,
    input logic blocked,
    input logic loaded
  );
    mode_step_ok = 1'b0;
    case (cur)
      secure_ctrl_pkg::MODE_STARTUP: begin
        mode_step_ok = loaded && !blocked &&
          ((req == secure_ctrl_pkg::MODE_VENDOR) ||
           ((req == secure_ctrl_pkg::MODE_FACTORY) && !delivered));
      end
      secure_ctrl_pkg::MODE_FACTORY: begin
        mode_step_ok = (req == secure_ctrl_pkg::MODE_VENDOR);
      end
      secure_ctrl_pkg::MODE_VENDOR: begin
        mode_step_ok = (req == secure_ctrl_pkg::MODE_SYSTEM);
      end
      default: begin
        mode_step_ok = (req == secure_ctrl_pkg::MODE_VENDOR);
      end
    endcase
  endfunction

  // Byte lane write with strobes; keep_ones leaves set bits set.
  function automatic logic [7:0] lane(
    input logic [7:0] old,
    input logic [31:0] wdata,
    input logic [3:0] strb,
    input int b,
    input logic keep_ones
  );
    logic [7:0] nb;
    nb = wdata[8*b +: 8];
    if (!strb[b]) begin
      lane = old;
    end else if (keep_ones) begin
      lane = old | nb;
    end else begin
      lane = nb;
    end
  endfunction

  // Single error correcting, double error detecting decode of one byte.
  function automatic logic [9:0] ecc_decode(input logic [secure_ctrl_pkg::ECC_W-1:0] c);
    logic [3:0] syn;
    logic overall;
    logic [secure_ctrl_pkg::ECC_W-1:0] fixed;
    logic corr;
    logic dbl;
    syn = 4'h0;
    fixed = c;
    corr = 1'b0;
    dbl = 1'b0;
    for (int i = 1; i < secure_ctrl_pkg::ECC_W; i++) begin
      if (c[i]) begin
        syn = syn ^ 4'(i);
      end
    end
    overall = ^c;
    if ((syn != 4'h0) && overall) begin
      if (syn < 4'(secure_ctrl_pkg::ECC_W)) begin
        fixed[syn] = ~c[syn];
        corr = 1'b1;
      end else begin
        dbl = 1'b1;
      end
    end else if (overall) begin
      corr = 1'b1;
    end else if (syn != 4'h0) begin
      dbl = 1'b1;
    end
    ecc_decode = {dbl, corr, fixed[12], fixed[11], fixed[10], fixed[9],
                  fixed[7], fixed[6], fixed[5], fixed[3]};
  endfunction

  assign setup_ph = psel && !penable;
  assign wr_acc = psel && penable && pwrite && !pslverr_r;
  assign pready = 1'b1;
  assign prdata = prdata_r;
  assign pslverr = pslverr_r;

  assign area_ok = (mode_r == secure_ctrl_pkg::MODE_FACTORY) ||
                   (mode_r == secure_ctrl_pkg::MODE_VENDOR) ||
                   ((mode_r == secure_ctrl_pkg::MODE_SYSTEM) && map_sys_r);

  assign in_ro = (paddr >= secure_ctrl_pkg::OFS_RO_AREA) && (paddr < secure_ctrl_pkg::OFS_WP_AREA);
  assign in_wp = (paddr >= secure_ctrl_pkg::OFS_WP_AREA) && (paddr < secure_ctrl_pkg::OFS_WO_AREA);
  assign in_wo = (paddr >= secure_ctrl_pkg::OFS_WO_AREA) &&
                 (paddr < secure_ctrl_pkg::OFS_WO_AREA + 12'(secure_ctrl_pkg::WO_BYTES));
  assign ro_idx = 4'((paddr - secure_ctrl_pkg::OFS_RO_AREA) >> 2);
  assign wp_idx = 4'((paddr - secure_ctrl_pkg::OFS_WP_AREA) >> 2);
  assign wo_idx = 4'((paddr - secure_ctrl_pkg::OFS_WO_AREA) >> 2);

  // Read data and the refusal answer are worked out in the setup cycle.
  always_comb begin
    rd_word = secure_ctrl_pkg::RESET_WORD;
    rd_err = 1'b0;
    if (paddr[1:0] != 2'b00) begin
      rd_err = 1'b1;
    end else if (paddr == secure_ctrl_pkg::OFS_MODE) begin
      rd_word = {30'h0, mode_r};
      rd_err = pwrite && !mode_step_ok(mode_r, secure_ctrl_pkg::mode_type'(pwdata[1:0]),
                                       delivered_r, startup_blocked_r, fuse_loaded_r);
    end else if (paddr == secure_ctrl_pkg::OFS_LIFE) begin
      rd_word[secure_ctrl_pkg::LIFE_DELIVERED_BIT] = delivered_r;
      rd_word[secure_ctrl_pkg::LIFE_BOOT_OFF_BIT] = boot_off_r;
      rd_err = pwrite && (mode_r != secure_ctrl_pkg::MODE_FACTORY) &&
               (mode_r != secure_ctrl_pkg::MODE_VENDOR);
    end else if (paddr == secure_ctrl_pkg::OFS_CONFIG) begin
      rd_word[3:0] = {fuse_r.card_dis_allowed, fuse_r.erase_allowed,
                      fuse_r.ram2_rd_par_en, fuse_r.ram1_rd_par_en};
      rd_word[secure_ctrl_pkg::CONFIG_LOADED_BIT] = fuse_loaded_r;
      rd_word[secure_ctrl_pkg::CONFIG_BLOCKED_BIT] = startup_blocked_r;
      rd_err = pwrite;
    end else if (paddr == secure_ctrl_pkg::OFS_MAP) begin
      rd_word[secure_ctrl_pkg::MAP_SYS_BIT] = map_sys_r;
      rd_err = pwrite && (mode_r != secure_ctrl_pkg::MODE_VENDOR);
    end else if (paddr == secure_ctrl_pkg::OFS_PROT) begin
      rd_word[secure_ctrl_pkg::PROT_WP_BIT] = wp_locked_r;
      rd_err = pwrite && !area_ok;
    end else if (paddr == secure_ctrl_pkg::OFS_CAUSE) begin
      rd_word[secure_ctrl_pkg::CAUSE_W-1:0] = cause_r;
    end else if (in_ro) begin
      rd_err = !area_ok || pwrite;
      for (int b = 0; b < 4; b++) begin
        rd_word[8*b +: 8] = RO_CONTENT[8*(4*ro_idx + b) +: 8];
      end
    end else if (in_wp) begin
      rd_err = !area_ok || (pwrite && wp_locked_r);
      for (int b = 0; b < 4; b++) begin
        rd_word[8*b +: 8] = wp_mem[4*wp_idx + b];
      end
    end else if (in_wo) begin
      rd_err = !area_ok;
      for (int b = 0; b < 4; b++) begin
        rd_word[8*b +: 8] = wo_mem[4*wo_idx + b];
      end
    end else begin
      rd_err = 1'b1;
    end
    if (rd_err) begin
      rd_word = secure_ctrl_pkg::RESET_WORD;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      prdata_r <= secure_ctrl_pkg::RESET_WORD;
      pslverr_r <= 1'b0;
    end else if (setup_ph) begin
      prdata_r <= rd_word;
      pslverr_r <= rd_err;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      mode_r <= secure_ctrl_pkg::MODE_STARTUP;
    end else if (wr_acc && (paddr == secure_ctrl_pkg::OFS_MODE)) begin
      mode_r <= secure_ctrl_pkg::mode_type'(pwdata[1:0]);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      fuse_r <= '0;
      fuse_loaded_r <= 1'b0;
      startup_blocked_r <= 1'b0;
    end else if (!fuse_loaded_r) begin
      fuse_r <= fuse_in;
      fuse_loaded_r <= 1'b1;
      startup_blocked_r <= fuse_in.card_dis_allowed &&
                           (wo_mem[secure_ctrl_pkg::CARD_DIS_BYTE] != 8'h00);
    end
  end

  assign fuse_err = fuse_loaded_r && (fuse_r.par != fuse_par(fuse_r));

  // Lifecycle, protection and write-once state live across chip resets.
  // delivery mark is cleared only by power-on reset
  always_ff @(posedge clk) begin
    if (!por_b) begin
      delivered_r <= 1'b0;
      boot_off_r <= 1'b0;
    end else if (wr_acc && (paddr == secure_ctrl_pkg::OFS_LIFE)) begin
      if (pwdata[secure_ctrl_pkg::LIFE_DELIVERED_BIT]) begin
        delivered_r <= 1'b1;
        boot_off_r <= 1'b1;
      end
      if (pwdata[secure_ctrl_pkg::LIFE_BOOT_OFF_BIT]) begin
        boot_off_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      map_sys_r <= 1'b0;
    end else if (wr_acc && (paddr == secure_ctrl_pkg::OFS_MAP)) begin
      map_sys_r <= pwdata[secure_ctrl_pkg::MAP_SYS_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (!por_b) begin
      wp_locked_r <= 1'b0;
    end else if (wr_acc && (paddr == secure_ctrl_pkg::OFS_PROT) &&
                 pwdata[secure_ctrl_pkg::PROT_WP_BIT]) begin
      wp_locked_r <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!por_b) begin
      for (int i = 0; i < secure_ctrl_pkg::WP_BYTES; i++) begin
        wp_mem[i] <= 8'h00;
      end
    end else if (wr_acc && in_wp) begin
      for (int b = 0; b < 4; b++) begin
        wp_mem[4*wp_idx + b] <= lane(wp_mem[4*wp_idx + b], pwdata, pstrb, b, 1'b0);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!por_b) begin
      for (int i = 0; i < secure_ctrl_pkg::WO_BYTES; i++) begin
        wo_mem[i] <= 8'h00;
      end
    end else if (wr_acc && in_wo) begin
      for (int b = 0; b < 4; b++) begin
        wo_mem[4*wo_idx + b] <= lane(wo_mem[4*wo_idx + b], pwdata, pstrb, b, 1'b1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      erase_all <= 1'b0;
    end else begin
      erase_all <= fuse_loaded_r && fuse_r.erase_allowed &&
                   (wo_mem[secure_ctrl_pkg::ERASE_BYTE] != 8'h00);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      nvm_out_valid_r <= 1'b0;
      nvm_out_data_r <= '0;
      nvm_out_corrected_r <= 1'b0;
      nvm_double_err <= 1'b0;
    end else begin
      logic [9:0] dec;
      dec = ecc_decode(nvm_rd_code);
      nvm_out_valid_r <= nvm_rd_valid && !dec[9];
      nvm_out_data_r <= dec[7:0];
      nvm_out_corrected_r <= nvm_rd_valid && dec[8] && !dec[9];
      nvm_double_err <= nvm_rd_valid && dec[9];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      for (int r = 0; r < secure_ctrl_pkg::NUM_RAMS; r++) begin
        scan_addr_r[r] <= '0;
      end
    end else begin
      for (int r = 0; r < secure_ctrl_pkg::NUM_RAMS; r++) begin
        scan_addr_r[r] <= scan_addr_r[r] + 1'b1;
      end
    end
  end

  always_comb begin
    err_now = '0;
    err_now[secure_ctrl_pkg::CAUSE_ROM_BIT] = par_fail(rom_word);
    err_now[secure_ctrl_pkg::CAUSE_NVM_BIT] = nvm_double_err;
    err_now[secure_ctrl_pkg::CAUSE_SCAN_BIT] = par_fail(ram_scan_word[0]) ||
                                              par_fail(ram_scan_word[1]);
    err_now[secure_ctrl_pkg::CAUSE_RD_BIT] =
      (fuse_r.ram1_rd_par_en && par_fail(ram_sw_word[0])) ||
      (fuse_r.ram2_rd_par_en && par_fail(ram_sw_word[1]));
    err_now[secure_ctrl_pkg::CAUSE_FUSE_BIT] = fuse_err ||
      (!fuse_loaded_r && (fuse_in.par != fuse_par(fuse_in)));
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      chip_reset_req_r <= 1'b0;
    end else begin
      chip_reset_req_r <= |err_now;
    end
  end

  // A cause that arrives with its clear is kept.
  always_ff @(posedge clk) begin
    if (!por_b) begin
      cause_r <= '0;
    end else if (wr_acc && (paddr == secure_ctrl_pkg::OFS_CAUSE)) begin
      cause_r <= (cause_r & ~pwdata[secure_ctrl_pkg::CAUSE_W-1:0]) | err_now;
    end else begin
      cause_r <= cause_r | err_now;
    end
  end

  assign chip_reset_req = chip_reset_req_r;
  assign cpu_mode = mode_r;
  assign nvm_out_valid = nvm_out_valid_r;
  assign nvm_out_data = nvm_out_data_r;
  assign nvm_out_corrected = nvm_out_corrected_r;
  assign ram_scan_addr = scan_addr_r;
  assign test_rom_en = (mode_r == secure_ctrl_pkg::MODE_FACTORY) && !delivered_r;
  assign bootloader_en = !boot_off_r;
  assign card_disabled = startup_blocked_r;

endmodule

// >>> secure_ctrl_checker.sv
// Concurrent checks on the ports of the secure mode and fuse area controller.
`timescale 1ns/1ps
module secure_ctrl_checker (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic por_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic pslverr,
  input wire secure_ctrl_pkg::fuse_word_type fuse_in,
  input wire secure_ctrl_pkg::mem_word_type rom_word,
  input wire logic nvm_rd_valid,
  input wire logic [secure_ctrl_pkg::ECC_W-1:0] nvm_rd_code,
  input wire logic nvm_out_valid,
  input wire secure_ctrl_pkg::mem_word_type ram_scan_word [secure_ctrl_pkg::NUM_RAMS],
  input wire secure_ctrl_pkg::mem_word_type ram_sw_word [secure_ctrl_pkg::NUM_RAMS],
  input wire logic chip_reset_req,
  input wire secure_ctrl_pkg::mode_type cpu_mode,
  input wire logic test_rom_en,
  input wire logic bootloader_en,
  input wire logic card_disabled
);
  function automatic logic bad(input secure_ctrl_pkg::mem_word_type w);
    return w.valid && (w.par != ^w.data);
  endfunction

  // Hamming syndrome over positions 1 to 12.
  function automatic logic [3:0] syn(input logic [12:0] c);
    logic [3:0] s;
    s = 4'h0;
    for (int p = 1; p < 13; p++) begin
      if (c[p]) s = s ^ 4'(p);
    end
    return s;
  endfunction

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  rom_parity_a: assert property (bad(rom_word) |=> chip_reset_req)
    else $error("rom parity fault without reset request");
  nvm_single_a: assert property (nvm_rd_valid && ^nvm_rd_code &&
    syn(nvm_rd_code) < 4'hd |=> nvm_out_valid)
    else $error("single bit error not corrected");
  nvm_double_a: assert property (
    nvm_rd_valid && !(^nvm_rd_code) && syn(nvm_rd_code) != 4'h0
    |=> !nvm_out_valid ##1 chip_reset_req) else $error("double error not answered by reset");
  scan_parity_a: assert property (
    bad(ram_scan_word[0]) || bad(ram_scan_word[1]) |=> chip_reset_req)
    else $error("scan parity fault without reset request");
  read_parity_a: assert property ($past(rst_b) && (
    (bad(ram_sw_word[0]) && fuse_in.ram1_rd_par_en) ||
    (bad(ram_sw_word[1]) && fuse_in.ram2_rd_par_en)) |=> chip_reset_req)
    else $error("read parity fault without reset request");
  reset_startup_a: assert property (disable iff (1'b0) !rst_b |=>
    cpu_mode == secure_ctrl_pkg::MODE_STARTUP) else $error("reset did not give startup");
  startup_entry_a: assert property (cpu_mode != secure_ctrl_pkg::MODE_STARTUP |=>
    cpu_mode != secure_ctrl_pkg::MODE_STARTUP) else $error("startup entered without reset");
  startup_exit_a: assert property (cpu_mode == secure_ctrl_pkg::MODE_STARTUP |=>
    cpu_mode != secure_ctrl_pkg::MODE_SYSTEM) else $error("startup left to system");
  vendor_exit_a: assert property (cpu_mode == secure_ctrl_pkg::MODE_VENDOR |=>
    cpu_mode != secure_ctrl_pkg::MODE_FACTORY) else $error("vendor entered factory");
  test_rom_a: assert property (test_rom_en |->
    cpu_mode == secure_ctrl_pkg::MODE_FACTORY) else $error("test rom enabled outside factory");
  boot_off_a: assert property (disable iff (!por_b) !bootloader_en |=>
    !bootloader_en) else $error("bootloader enabled again");
  fuse_check_a: assert property (rst_b && !$past(rst_b) && ^fuse_in |->
    ##1 chip_reset_req ##1 chip_reset_req) else $error("fuse parity fault without reset request");
  ro_write_a: assert property (psel && penable && pwrite &&
    paddr >= secure_ctrl_pkg::OFS_RO_AREA && paddr < secure_ctrl_pkg::OFS_WP_AREA |-> pslverr)
    else $error("read-only write not refused");
  card_block_a: assert property (card_disabled |->
    cpu_mode == secure_ctrl_pkg::MODE_STARTUP) else $error("card disabled but mode left startup");
endmodule

bind secure_ctrl secure_ctrl_checker chk_i (.clk, .rst_b, .por_b, .psel, .penable, .pwrite,
  .paddr, .pslverr, .fuse_in, .rom_word, .nvm_rd_valid, .nvm_rd_code, .nvm_out_valid,
  .ram_scan_word, .ram_sw_word, .chip_reset_req, .cpu_mode, .test_rom_en, .bootloader_en,
  .card_disabled);

// >>> secure_ctrl_tb_top.sv
// Self-checking bench for the secure mode and fuse area controller.
`timescale 1ns/1ps
module secure_ctrl_tb_top;
  // Flags f: bit 2 reset before, bit 1 write, bit 0 refusal expected.
  typedef struct packed {
    logic [2:0] f;
    logic [11:0] a;
    logic [31:0] d;
    logic [31:0] r;
  } row_type;
  localparam logic [31:0] RV = 32'ha5c3_0f96;
  localparam logic [11:0] MD = secure_ctrl_pkg::OFS_MODE;
  localparam logic [11:0] LF = secure_ctrl_pkg::OFS_LIFE;
  localparam logic [11:0] MP = secure_ctrl_pkg::OFS_MAP;
  localparam logic [11:0] PR = secure_ctrl_pkg::OFS_PROT;
  localparam logic [11:0] RO = secure_ctrl_pkg::OFS_RO_AREA;
  localparam logic [11:0] WP = secure_ctrl_pkg::OFS_WP_AREA;
  localparam logic [11:0] WO = secure_ctrl_pkg::OFS_WO_AREA;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic por_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] prdata, rd;
  logic pready, pslverr, er;
  secure_ctrl_pkg::fuse_word_type fuse_in = 5'h1b;
  secure_ctrl_pkg::mem_word_type rom_word = '0;
  logic nvm_rd_valid = 1'b0;
  logic [12:0] nvm_rd_code = 13'h0;
  logic nvm_out_valid, nvm_out_corrected, chip_reset_req, test_rom_en;
  logic bootloader_en, card_disabled, erase_all;
  logic [7:0] nvm_out_data;
  logic [3:0] scan_addr [2];
  secure_ctrl_pkg::mem_word_type ram_scan_word [2] = '{default: '0};
  secure_ctrl_pkg::mem_word_type ram_sw_word [2] = '{default: '0};
  secure_ctrl_pkg::mode_type cpu_mode;
  int num_errors = 0;
  int check_count = 0;
  row_type rows [33] = '{
    '{3'h0, MD, 32'h0, 32'h0}, '{3'h3, MD, 32'h3, 32'h0}, '{3'h3, PR, 32'h1, 32'h0},
    '{3'h2, MD, 32'h2, 32'h0}, '{3'h0, MD, 32'h0, 32'h2}, '{3'h3, MD, 32'h0, 32'h0},
    '{3'h2, MD, 32'h1, 32'h0}, '{3'h3, MD, 32'h2, 32'h0}, '{3'h2, MD, 32'h3, 32'h0},
    '{3'h1, RO, 32'h0, 32'h0}, '{3'h2, MD, 32'h1, 32'h0}, '{3'h2, MP, 32'h1, 32'h0},
    '{3'h2, MD, 32'h3, 32'h0}, '{3'h0, RO, 32'h0, RV}, '{3'h3, RO, 32'hffff_ffff, 32'h0},
    '{3'h0, RO, 32'h0, RV}, '{3'h1, 12'h200, 32'h0, 32'h0}, '{3'h2, WP, 32'h1122_3344, 32'h0},
    '{3'h0, WP, 32'h0, 32'h1122_3344}, '{3'h2, PR, 32'h1, 32'h0}, '{3'h3, WP, 32'h5, 32'h0},
    '{3'h0, WP, 32'h0, 32'h1122_3344}, '{3'h2, WO + 12'h4, 32'hf0, 32'h0},
    '{3'h2, WO + 12'h4, 32'h0f, 32'h0}, '{3'h2, WO + 12'h4, 32'h0, 32'h0},
    '{3'h0, WO + 12'h4, 32'h0, 32'hff}, '{3'h2, MD, 32'h1, 32'h0}, '{3'h2, LF, 32'h1, 32'h0},
    '{3'h0, LF, 32'h0, 32'h3}, '{3'h7, MD, 32'h2, 32'h0}, '{3'h2, MD, 32'h1, 32'h0},
    '{3'h2, WO, 32'h0101, 32'h0}, '{3'h7, MD, 32'h1, 32'h0}};

  secure_ctrl #(.RAM_AW(4), .RO_CONTENT({8{RV}})) dut (.clk, .rst_b, .por_b, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .fuse_in, .rom_word,
    .nvm_rd_valid, .nvm_rd_code, .nvm_out_valid, .nvm_out_data, .nvm_out_corrected,
    .ram_scan_addr(scan_addr), .ram_scan_word, .ram_sw_word, .chip_reset_req, .cpu_mode, .test_rom_en,
    .bootloader_en, .card_disabled, .erase_all);

  always #12.5 clk = ~clk;

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic report_and_stop();
    if (num_errors == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic do_reset(input logic p);
    @(posedge clk);
    rst_b <= 1'b0;
    por_b <= p;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    por_b <= 1'b1;
    repeat (3) @(posedge clk);
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic hit(input int lat, input logic e, input string nm);
    repeat (lat) @(posedge clk);
    #1;
    chk(nm, {31'h0, e}, {31'h0, chip_reset_req});
  endtask

  task automatic clr();
    @(posedge clk);
    rom_word <= '0;
    nvm_rd_valid <= 1'b0;
    ram_scan_word <= '{default: '0};
    ram_sw_word <= '{default: '0};
    repeat (3) @(posedge clk);
  endtask

  function automatic logic [12:0] enc(input logic [7:0] d);
    logic [12:0] c;
    c = 13'h0;
    {c[12:9], c[7:5], c[3]} = d;
    for (int i = 3; i < 13; i++) begin
      for (int k = 0; k < 4; k++) begin
        if (i[k] && i != (1 << k)) c[1 << k] = c[1 << k] ^ c[i];
      end
    end
    c[0] = ^c[12:1];
    return c;
  endfunction

  initial begin
    do_reset(1'b0);
    chk("mode", secure_ctrl_pkg::MODE_STARTUP, cpu_mode);
    for (int i = 0; i < 33; i++) begin
      if (rows[i].f[2]) do_reset(1'b1);
      apb(rows[i].f[1], rows[i].a, rows[i].d);
      chk("refusal", {31'h0, rows[i].f[0]}, {31'h0, er});
      if (!rows[i].f[1]) chk("read data", rows[i].r, rd);
      if (i == 4) chk("test rom on", 32'h1, {31'h0, test_rom_en});
      if (i == 4) chk("bootloader on", 32'h1, {31'h0, bootloader_en});
    end
    #1;
    chk("card disabled", 32'h1, {31'h0, card_disabled});
    chk("erase", 32'h1, {31'h0, erase_all});
    chk("bootloader", 32'h0, {31'h0, bootloader_en});
    chk("test rom", 32'h0, {31'h0, test_rom_en});
    rd[3:0] = scan_addr[0];
    @(posedge clk);
    #1;
    chk("scan addr", {28'h0, rd[3:0] + 4'h1}, {28'h0, scan_addr[0]});
    @(posedge clk) rom_word <= '{1'b1, 8'h01, 1'b0};
    hit(1, 1'b1, "rom fault");
    clr();
    @(posedge clk) rom_word <= '{1'b1, 8'h03, 1'b0};
    hit(1, 1'b0, "rom clean");
    clr();
    @(posedge clk) nvm_rd_valid <= 1'b1;
    nvm_rd_code <= enc(8'h5c) ^ 13'h0040;
    hit(1, 1'b0, "nvm single");
    chk("nvm data", 32'h5c, {24'h0, nvm_out_data});
    chk("nvm corrected", 32'h1, {31'h0, nvm_out_corrected});
    clr();
    @(posedge clk) nvm_rd_valid <= 1'b1;
    nvm_rd_code <= enc(8'h5c) ^ 13'h0060;
    hit(2, 1'b1, "nvm double");
    chk("nvm valid", 32'h0, {31'h0, nvm_out_valid});
    clr();
    @(posedge clk) ram_scan_word[1] <= '{1'b1, 8'h01, 1'b0};
    hit(1, 1'b1, "scan fault");
    clr();
    @(posedge clk) ram_sw_word[0] <= '{1'b1, 8'h01, 1'b0};
    hit(1, 1'b1, "read parity on");
    clr();
    @(posedge clk) ram_sw_word[1] <= '{1'b1, 8'h01, 1'b0};
    hit(1, 1'b0, "read parity off");
    clr();
    @(posedge clk) fuse_in <= 5'h1a;
    do_reset(1'b1);
    hit(0, 1'b1, "fuse fault");
    report_and_stop();
  end

  // The sequence needs well under two thousand cycles; this bounds any hang.
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    report_and_stop();
  end
endmodule
